// File: core/urre_top.sv
// UART receiver back end: start detection, majority voting, error flags
// and a two-character receive buffer behind an AXI4-Lite slave.
// Assumes rxd_i is asynchronous and that the bus master keeps AXI rules.
`timescale 1ns/1ps

// Behaviour
// R1: status bits travel with each buffered character
// R2: software writes cannot change error flags
// R3: error flags raise no interrupt
// R4: frame error shows head character's stop bit
// R5: only first stop bit checked, count ignored
// R6: overrun on start with full buffer, waiting
// R7: overrun cleared when frame enters buffer
// R8: parity error reads zero when checking off
// R9: upper mode bit enables, lower selects odd
// R10: parity error stored only if enabled then
// R11: disable stops reception at once, data lost
// R12: disabled: pin released, buffer flushed
// R13: host flushes by reading data until empty
// R14: data read advances buffer; status first
// R15: sample at 16x, or 8x in double speed
// R16: falling edge starts; vote samples 8-10/4-6
// R17: majority high rejects start as noise
// R18: 16 or 8 sample states per bit
// R19: each bit decided by three-sample majority
// R20: voted zero stop bit sets frame error
// R21: next start right after stop vote, later 8x
// R22: completed frame moved into receive buffer
// R23: receive complete while buffer holds data
// R24: vote positions 8-10 of 16, 4-6 of 8
// R25: serial input double-synchronised before use
module urre_top
   import urre_pkg::*;
#(
   parameter int ADDR_W = 4
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic rxd_i,
   output logic rx_pin_owned_o,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // Register select, used by both the write and read paths
   function automatic logic [4:0] reg_sel(input logic [ADDR_W-1:0] a);
      reg_sel[0] = (a[3:2] == URRE_OFF_CTRL[3:2]);
      reg_sel[1] = (a[3:2] == URRE_OFF_BAUD[3:2]);
      reg_sel[2] = (a[3:2] == URRE_OFF_STAT[3:2]);
      reg_sel[3] = (a[3:2] == URRE_OFF_DATA[3:2]);
      reg_sel[4] = (ADDR_W > 4) ? (a >> 4) != '0 : 1'b0; // Out of map
   endfunction

   // Majority of three samples
   function automatic logic maj3(input logic [2:0] v);
      maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
   endfunction

   urre_ctrl_s ctrl_q;
   logic [15:0] baud_q;
   logic rx_meta_q;
   logic rx_sync_q;
   logic prev_q;
   logic [15:0] div_q;
   logic tick_q;
   urre_state_e state_q;
   logic [3:0] samp_q;
   logic [2:0] bit_q;
   logic [2:0] vote_q;
   logic [7:0] shift_q;
   logic par_q;
   logic fr_u2x_q;
   logic fr_pen_q;
   logic fr_odd_q;
   urre_entry_s hold_q;
   logic hold_v_q;
   logic dor_pend_q;
   logic aw_hold_q;
   logic w_hold_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;

   urre_entry_s head;
   logic buf_empty;
   logic buf_full;

   // Input synchroniser; only the second stage is read
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         rx_meta_q <= 1'b1;
         rx_sync_q <= 1'b1;
      end else begin
         rx_meta_q <= rxd_i; // R25
         rx_sync_q <= rx_meta_q; // R25
      end
   end

   // Sample tick divider: one enable pulse every baud_q+1 cycles
   wire div_end = (div_q == baud_q);
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i || !ctrl_q.receive_enable_bit) begin
         div_q <= '0;
         tick_q <= 1'b0;
      end else begin
         div_q <= div_end ? '0 : div_q + 16'h0001;
         tick_q <= div_end; // R15
      end
   end

   // Per-frame mode, latched at the start edge so a mid-frame write
   // to the control register cannot tear a frame apart
   wire [3:0] spb = fr_u2x_q ? URRE_SPB_DS : URRE_SPB_NORM; // R15 R18
   wire [3:0] vfirst = fr_u2x_q ? URRE_VF_DS : URRE_VF_NORM; // R24
   wire [3:0] vlast = fr_u2x_q ? URRE_VL_DS : URRE_VL_NORM; // R16 R24
   wire in_vote = (samp_q >= vfirst) && (samp_q <= vlast);
   wire [2:0] votes = {vote_q[1:0], rx_sync_q};
   wire voted = maj3(votes); // R19
   wire at_decide = tick_q && (samp_q == vlast);
   wire at_bit_end = tick_q && (samp_q == spb);
   wire fall_edge = tick_q && prev_q && !rx_sync_q; // R16
   wire start_ok = (state_q == URRE_START) && at_decide && !voted; // R17
   wire stop_done = (state_q == URRE_STOP) && at_decide; // R5
   wire overrun = start_ok && hold_v_q && buf_full; // R6
   wire par_calc = ^shift_q ^ fr_odd_q; // R9
   wire par_err = fr_pen_q && (par_calc != par_q); // R10

   // Receive state machine, one sample state per tick
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i || !ctrl_q.receive_enable_bit) begin
         state_q <= URRE_IDLE; // R11
         samp_q <= '0;
         bit_q <= '0;
         vote_q <= '0;
         prev_q <= 1'b0; // Line must be seen high before an edge counts
      end else if (tick_q) begin
         prev_q <= rx_sync_q;
         samp_q <= (samp_q == spb) ? '0 : samp_q + 4'h1; // R18
         if (in_vote) vote_q <= votes;
         unique case (state_q)
            URRE_IDLE: begin
               samp_q <= 4'h1; // First low sample is sample 1
               if (fall_edge) state_q <= URRE_START; // R16
            end
            URRE_START: begin
               if (at_decide && voted) state_q <= URRE_IDLE; // R17
               else if (at_bit_end) state_q <= URRE_DATA;
            end
            URRE_DATA: begin
               if (at_bit_end) begin
                  bit_q <= bit_q + 3'h1;
                  if (bit_q == 3'h7) begin
                     state_q <= fr_pen_q ? URRE_PAR : URRE_STOP;
                  end
               end
            end
            URRE_PAR: begin
               if (at_bit_end) state_q <= URRE_STOP;
            end
            URRE_STOP: begin
               // Normal speed re-arms right after the last vote
               if (at_decide) begin
                  state_q <= fr_u2x_q ? URRE_GAP : URRE_IDLE; // R21
               end
            end
            URRE_GAP: begin
               if (at_bit_end) state_q <= URRE_IDLE; // R21
            end
         endcase
      end
   end

   // Data path: frame mode, shift register and parity capture
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         fr_u2x_q <= 1'b0;
         fr_pen_q <= 1'b0;
         fr_odd_q <= 1'b0;
         shift_q <= '0;
         par_q <= 1'b0;
      end else begin
         if (state_q == URRE_IDLE && fall_edge) begin
            fr_u2x_q <= ctrl_q.u2x; // R15
            fr_pen_q <= ctrl_q.pen; // R9 R10
            fr_odd_q <= ctrl_q.odd; // R9
         end
         if (state_q == URRE_DATA && at_decide) begin
            shift_q <= {voted, shift_q[7:1]}; // R19
         end
         if (state_q == URRE_PAR && at_decide) par_q <= voted; // R19
      end
   end

   // Completed frame waits in the hold stage until the buffer has room;
   // a start bit seen while it waits on a full buffer loses it
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i || !ctrl_q.receive_enable_bit) begin
         hold_v_q <= 1'b0; // R11
         hold_q <= '0;
         dor_pend_q <= 1'b0;
      end else begin
         if (overrun) begin
            hold_v_q <= 1'b0;
            dor_pend_q <= 1'b1; // R6
         end else if (stop_done) begin
            hold_v_q <= 1'b1; // R22
            hold_q.data <= shift_q;
            hold_q.fe <= !voted; // R4 R20
            hold_q.pe <= par_err; // R10
            hold_q.overrun_flag <= dor_pend_q; // R1
         end else if (hold_v_q && !buf_full) begin
            hold_v_q <= 1'b0;
            dor_pend_q <= 1'b0; // R7
         end
      end
   end

   // Read side: a data read pops the head
   wire ar_hs = s_axi_arvalid && s_axi_arready;
   wire [4:0] rsel = reg_sel(s_axi_araddr);
   wire r_err = rsel[4];
   wire pop = ar_hs && rsel[3] && !r_err; // R14 R13

   urre_rxbuf #(
      .DEPTH(URRE_BUF_DEPTH)
   ) u_buf (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .flush_i(!ctrl_q.receive_enable_bit), // R12
      .push_i(hold_v_q && !overrun), // R1 R22
      .push_entry_i(hold_q),
      .pop_i(pop),
      .head_o(head),
      .empty_o(buf_empty),
      .full_o(buf_full)
   );

   // Status view of the head character; error flags never leave the
   // block except through this word
   wire [31:0] stat_word = {
      24'h000000,
      !buf_empty, // R23
      2'b00,
      head.fe && !buf_empty, // R4
      head.overrun_flag && !buf_empty, // R1
      head.pe && !buf_empty && ctrl_q.pen, // R8
      2'b00
   }; // R3

   wire [31:0] rd_word =
      rsel[0] ? {27'h0, ctrl_q} :
      rsel[1] ? {16'h0000, baud_q} :
      rsel[2] ? stat_word :
      buf_empty ? 32'h00000000 : {24'h000000, head.data};

   // Read channel: one read outstanding at a time
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= URRE_RESP_OKAY;
      end else if (ar_hs) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= r_err ? 32'h00000000 : rd_word;
         s_axi_rresp <= r_err ? URRE_RESP_SLVERR : URRE_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Write side: address and data taken in either order
   wire aw_hs = s_axi_awvalid && s_axi_awready;
   wire w_hs = s_axi_wvalid && s_axi_wready;
   wire wr_do = aw_hold_q && w_hold_q && !s_axi_bvalid;
   wire aw_hold_d = (aw_hold_q || aw_hs) && !wr_do;
   wire w_hold_d = (w_hold_q || w_hs) && !wr_do;
   wire [4:0] wsel = reg_sel(awaddr_q);
   wire w_err = wsel[4];

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else begin
         aw_hold_q <= aw_hold_d;
         w_hold_q <= w_hold_d;
         s_axi_awready <= !aw_hold_d;
         s_axi_wready <= !w_hold_d;
         if (aw_hs) awaddr_q <= s_axi_awaddr;
         if (w_hs) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
      end
   end

   // Write response and register update; status and data are
   // read-only, so writes there change nothing
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= URRE_RESP_OKAY;
         ctrl_q <= URRE_CTRL_RST;
         baud_q <= URRE_BAUD_RST;
      end else begin
         if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= w_err ? URRE_RESP_SLVERR : URRE_RESP_OKAY;
            if (!w_err && wsel[0] && wstrb_q[0]) begin
               ctrl_q <= wdata_q[4:0]; // R11 R12
            end
            if (!w_err && wsel[1]) begin
               if (wstrb_q[0]) baud_q[7:0] <= wdata_q[7:0];
               if (wstrb_q[1]) baud_q[15:8] <= wdata_q[15:8];
            end
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end // R2

   // Pin ownership follows the enable
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         rx_pin_owned_o <= 1'b0;
      end else begin
         rx_pin_owned_o <= ctrl_q.receive_enable_bit; // R12
      end
   end

endmodule

// File: common/urre_pkg.sv
// Constants and carrier types for the UART receive/recovery block.
// Assumes one 200 MHz system clock and an AXI4-Lite register port.
package urre_pkg;

   // Clock rate, for converting times to cycles
   localparam int unsigned URRE_CLK_HZ = 200_000_000;

   // Register byte offsets
   localparam logic [3:0] URRE_OFF_CTRL = 4'h0;
   localparam logic [3:0] URRE_OFF_BAUD = 4'h4;
   localparam logic [3:0] URRE_OFF_STAT = 4'h8;
   localparam logic [3:0] URRE_OFF_DATA = 4'hC;

   // Control field positions
   localparam int URRE_CTRL_RECEIVE_ENABLE_BIT_POS = 0;
   localparam int URRE_CTRL_U2X_POS = 1;
   localparam int URRE_CTRL_ODD_POS = 2;
   localparam int URRE_CTRL_PEN_POS = 3;
   localparam int URRE_CTRL_STOP2_POS = 4;

   // Status field positions
   localparam int URRE_STAT_PE_POS = 2;
   localparam int URRE_STAT_DOR_POS = 3;
   localparam int URRE_STAT_FE_POS = 4;
   localparam int URRE_STAT_RXC_POS = 7;

   // Reset values
   localparam logic [4:0] URRE_CTRL_RST = 5'h00;
   localparam logic [15:0] URRE_BAUD_RST = 16'h0000;

   // Samples per bit and voting positions per mode
   localparam logic [3:0] URRE_SPB_NORM = 4'hF;  // 16 samples, last is 15
   localparam logic [3:0] URRE_SPB_DS = 4'h7;    // 8 samples, last is 7
   localparam logic [3:0] URRE_VF_NORM = 4'h7;   // Sample 8, counted from 1
   localparam logic [3:0] URRE_VL_NORM = 4'h9;   // Sample 10
   localparam logic [3:0] URRE_VF_DS = 4'h3;     // Sample 4
   localparam logic [3:0] URRE_VL_DS = 4'h5;     // Sample 6

   // AXI responses
   localparam logic [1:0] URRE_RESP_OKAY = 2'h0;
   localparam logic [1:0] URRE_RESP_SLVERR = 2'h2;

   // Receive buffer depth
   localparam int URRE_BUF_DEPTH = 2;

   // One buffered character with its own status
   typedef struct packed {
      logic fe;
      logic overrun_flag;
      logic pe;
      logic [7:0] data;
   } urre_entry_s;

   // Software control fields
   typedef struct packed {
      logic stop2;
      logic pen;
      logic odd;
      logic u2x;
      logic receive_enable_bit;
   } urre_ctrl_s;

   typedef enum logic [2:0] {
      URRE_IDLE, URRE_START, URRE_DATA, URRE_PAR, URRE_STOP, URRE_GAP
   } urre_state_e;

endpackage

// File: core/urre_rxbuf.sv
// Receive buffer: small circular store of characters with their status.
// A push made while full is dropped; flush wins over everything.
`timescale 1ns/1ps
module urre_rxbuf
   import urre_pkg::*;
#(
   parameter int DEPTH = URRE_BUF_DEPTH
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic flush_i,
   input wire logic push_i,
   input wire urre_entry_s push_entry_i,
   input wire logic pop_i,
   output urre_entry_s head_o,
   output logic empty_o,
   output logic full_o
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   urre_entry_s mem_q [DEPTH];
   logic [PW-1:0] wp_q;
   logic [PW-1:0] rp_q;
   logic [PW:0] cnt_q;
   wire do_push = push_i & ~full_o;
   wire do_pop = pop_i & ~empty_o;

   // Pointer step with wrap for non-power-of-two depths
   function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
      step = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign head_o = mem_q[rp_q];
   assign empty_o = (cnt_q == '0);
   assign full_o = (cnt_q == (PW + 1)'(DEPTH));

   // Storage needs no reset; only the count says what is valid
   always_ff @(posedge sys_clk_i) begin
      if (do_push) begin
         mem_q[wp_q] <= push_entry_i;
      end
   end

   // Pointers and count; flush empties at once
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i || flush_i) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (do_push) wp_q <= step(wp_q);
         if (do_pop) rp_q <= step(rp_q);
         cnt_q <= cnt_q + (PW + 1)'(do_push) - (PW + 1)'(do_pop);
      end
   end
endmodule

// File: test/urre_checker.sv
// Checks on the receiver's register port and its pin ownership flag.
// Assumes it is bound onto urre_top and sees only its ports.
`timescale 1ns/1ps
module urre_checker
   import urre_pkg::*;
#(
   parameter int ADDR_W = 4
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic rx_pin_owned_o,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   logic [ADDR_W-1:0] ra_q;
   logic [1:0] ersp_w;
   // Word asked for by the read now in flight
   always_ff @(posedge sys_clk_i) begin
      if (s_axi_arvalid && s_axi_arready) begin
         ra_q <= s_axi_araddr;
      end
   end
   // Anything above the four decoded bits is refused
   assign ersp_w = (ra_q >> 4) != '0 ? URRE_RESP_SLVERR : URRE_RESP_OKAY;
   sequence ar_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence r_stall;
      s_axi_rvalid && !s_axi_rready;
   endsequence
   // Status read while the pin was released for two cycles
   sequence stat_off;
      ar_take ##0 (s_axi_araddr == URRE_OFF_STAT && !rx_pin_owned_o
         && !$past(rx_pin_owned_o));
   endsequence
   rd_latency_a: assert property (ar_take |=> s_axi_rvalid)
      else $error("read answer late");
   rd_hold_a: assert property (r_stall |=> s_axi_rvalid &&
      $stable(s_axi_rdata)) else $error("read data not held");
   rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("second read accepted");
   rd_resp_a: assert property (s_axi_rvalid |-> s_axi_rresp == ersp_w)
      else $error("wrong read response");
   wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer lost");
   empty_flags_a: assert property (
      s_axi_rvalid && ra_q == URRE_OFF_STAT && !s_axi_rdata[7]
      |-> s_axi_rdata[4:2] == 3'h0) else $error("flags without data");
   off_empty_a: assert property (stat_off |=> !s_axi_rdata[7])
      else $error("data kept while disabled");
   pin_owner_a: assert property ($changed(rx_pin_owned_o) |->
      $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
      else $error("pin owner changed without write");
endmodule

bind urre_top urre_checker #(.ADDR_W(ADDR_W)) chk (
   .sys_clk_i,
   .rst_n_i,
   .rx_pin_owned_o,
   .s_axi_bvalid,
   .s_axi_bready,
   .s_axi_bresp,
   .s_axi_araddr,
   .s_axi_arvalid,
   .s_axi_arready,
   .s_axi_rdata,
   .s_axi_rresp,
   .s_axi_rvalid,
   .s_axi_rready
);

// File: test/urre_uart_model.sv
// Remote transmitter driving the serial line into the receiver.
// Assumes one caller at a time; line idles high between frames.
`timescale 1ns/1ps
module urre_uart_model (
   input wire logic sys_clk_i,
   output logic rxd_o
);
   initial rxd_o = 1'b1;
   // One bit held for cpb clocks, changed just after an edge
   task automatic bit_out(input logic v, input int cpb);
      rxd_o <= v;
      repeat (cpb) @(posedge sys_clk_i);
   endtask
   // Start, eight data bits LSB first, optional parity, one stop
   task automatic send(input logic [7:0] d, input int cpb, input logic pen,
      input logic odd, input logic perr, input logic stp);
      bit_out(1'b0, cpb);
      for (int i = 0; i < 8; i++) bit_out(d[i], cpb);
      if (pen) bit_out(^d ^ odd ^ perr, cpb);
      bit_out(stp, cpb);
      if (!stp) rxd_o <= 1'b1;
   endtask
   // Low pulse too short to survive the start vote
   task automatic glitch(input int n);
      bit_out(1'b0, n);
      rxd_o <= 1'b1;
   endtask
endmodule

// File: test/test_urre_top.sv
// Self-checking bench: reads and writes queue their expectations and
// a monitor compares each bus answer. Assumes a 200 MHz clock.
`timescale 1ns/1ps
module test_urre_top
   import urre_pkg::*;
;
   typedef struct {logic [31:0] e; logic [31:0] m; logic [1:0] r;} urre_note_s;
   logic sys_clk_i, rst_n_i, rxd_i, rx_pin_owned_o;
   logic [4:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   int fail_count = 0;
   int total_checks = 0;
   logic [31:0] rng = 32'h0000001B;
   urre_note_s notes[$];
   urre_note_s cur;
   logic [1:0] bnotes[$];
   logic [1:0] bexp;

   urre_top #(.ADDR_W(5)) dut (.sys_clk_i, .rst_n_i, .rxd_i, .rx_pin_owned_o,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   urre_uart_model tx (.sys_clk_i, .rxd_o(rxd_i));

   // Free-running 5 ns clock
   initial begin
      sys_clk_i = 1'b0;
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end

   function automatic logic [31:0] next_rand();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction

   task automatic check(input string nm, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic final_report();
      $display("Checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Write: both channels offered together, answer taken a cycle late
   task automatic wr(input logic [4:0] a, input logic [31:0] d,
      input logic [1:0] r = 2'h0);
      bit ap, wp;
      ap = 1;
      wp = 1;
      @(posedge sys_clk_i);
      bnotes.push_back(r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (ap || wp) begin
         @(posedge sys_clk_i);
         if (ap && s_axi_awready) begin
            ap = 0;
            s_axi_awvalid <= 1'b0;
         end
         if (wp && s_axi_wready) begin
            wp = 0;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge sys_clk_i); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b1;
      @(posedge sys_clk_i);
      s_axi_bready <= 1'b0;
   endtask

   // Read: expectation queued first; late ready makes the slave hold
   task automatic rd(input logic [4:0] a, input logic [31:0] e,
      input logic [31:0] m = 32'hFFFFFFFF, input logic [1:0] r = 2'h0);
      @(posedge sys_clk_i);
      notes.push_back('{e & m, m, r});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge sys_clk_i); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge sys_clk_i); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b1;
      @(posedge sys_clk_i);
      s_axi_rready <= 1'b0;
   endtask

   task automatic frame(input logic [7:0] d, input int cpb, input logic pen,
      input logic odd, input logic perr, input logic stp);
      tx.send(d, cpb, pen, odd, perr, stp);
      repeat (10) @(posedge sys_clk_i);
   endtask

   // Status first, then the character, since the data read pops
   task automatic chk_char(input logic [7:0] d, input logic [7:0] st);
      rd(5'h08, {24'h0, st}, 32'h0000009C);
      rd(5'h0C, {24'h0, d});
   endtask

   // Compare each read answer with the oldest note
   always @(posedge sys_clk_i) begin
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
         cur = notes.pop_front();
         check("rdata", s_axi_rdata & cur.m, cur.e);
         check("rresp", {30'h0, s_axi_rresp}, {30'h0, cur.r});
      end
      // Write answers against the oldest write note
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
         bexp = bnotes.pop_front();
         check("bresp", {30'h0, s_axi_bresp}, {30'h0, bexp});
      end
   end

   // Watchdog, a generous multiple of the frames sent
   initial begin
      repeat (40000) @(posedge sys_clk_i);
      fail_count++;
      final_report();
   end

   initial begin
      logic [7:0] b;
      logic [7:0] c [4];
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
      rst_n_i = 1'b0;
      repeat (8) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      // Out-of-map write must be refused and leave control alone
      wr(5'h10, 32'h1F, URRE_RESP_SLVERR);
      rd(5'h00, 32'h0);
      rd(5'h04, 32'h0);
      rd(5'h08, 32'h0, 32'h0000009C);
      rd(5'h10, 32'h0, 32'hFFFFFFFF, URRE_RESP_SLVERR);
      check("owned", {31'h0, rx_pin_owned_o}, 32'h0);
      $display("Test reset finished");
      wr(5'h00, 32'h01);
      check("owned", {31'h0, rx_pin_owned_o}, 32'h1);
      b = 8'(next_rand());
      frame(b, 16, 0, 0, 1, 1);
      chk_char(b, 8'h80);
      rd(5'h08, 32'h0, 32'h0000009C);
      wr(5'h00, 32'h11);
      b = 8'(next_rand());
      frame(b, 16, 0, 0, 0, 0);
      wr(5'h08, 32'h0);
      wr(5'h0C, 32'h0);
      chk_char(b, 8'h90);
      $display("Test normal finished");
      for (int i = 0; i < 4; i++) begin
         wr(5'h00, {28'h0, 1'b1, i[0], 2'b01});
         b = 8'(next_rand());
         frame(b, 16, 1, i[0], i[1], 1);
         chk_char(b, {1'b1, 4'h0, i[1], 2'b00});
      end
      wr(5'h00, 32'h01);
      tx.glitch(4);
      // Long enough for a wrongly accepted start to finish a frame
      repeat (200) @(posedge sys_clk_i);
      rd(5'h08, 32'h0, 32'h0000009C);
      $display("Test parity finished");
      for (int i = 0; i < 4; i++) begin
         c[i] = 8'(next_rand());
         tx.send(c[i], 16, 0, 0, 0, 1);
      end
      repeat (10) @(posedge sys_clk_i);
      chk_char(c[0], 8'h80);
      chk_char(c[1], 8'h80);
      chk_char(c[3], 8'h88);
      b = 8'(next_rand());
      frame(b, 16, 0, 0, 0, 1);
      chk_char(b, 8'h80);
      // Software flush: data reads until the buffer reads empty
      frame(b, 16, 0, 0, 0, 1);
      frame(b, 16, 0, 0, 0, 1);
      rd(5'h0C, {24'h0, b});
      rd(5'h0C, {24'h0, b});
      rd(5'h08, 32'h0, 32'h0000009C);
      $display("Test overrun finished");
      frame(b, 16, 0, 0, 0, 1);
      fork
         tx.send(8'hFF, 16, 0, 0, 0, 1);
         begin
            repeat (40) @(posedge sys_clk_i);
            wr(5'h00, 32'h0);
            wr(5'h00, 32'h01);
         end
      join
      repeat (10) @(posedge sys_clk_i);
      rd(5'h08, 32'h0, 32'h0000009C);
      rd(5'h0C, 32'h0);
      $display("Test disable finished");
      wr(5'h04, 32'h01);
      rd(5'h04, 32'h01);
      wr(5'h00, 32'h03);
      b = 8'(next_rand());
      frame(b, 16, 0, 0, 0, 1);
      chk_char(b, 8'h80);
      $display("Test double speed finished");
      final_report();
   end
endmodule
